// >>> src/tmo_timer.sv
// 16-bit timer with clock selection, prescaler and capture/compare unit
// Behaviour
// - the 16-bit count is the time base of the capture/compare unit.
// - in capture mode a capture event copies the count into the capture pair.
// - in compare mode, pair equal to count raises a compare event.
// - a compare event can act as special trigger, accepted by the timer.
// - the special trigger clears both count bytes to zero.
// - a trigger clear never sets the overflow flag.
// - with the trigger in use the count clears two clock cycles after it reaches the compare value.
// - a count byte write in the same cycle as a trigger clear wins.
// - source 00 instruction clock, 01 system clock, 11 sensing oscillator.
// - source 10 is pin rising edge, or crystal when oscillator enable set.
// - prescaler divides the selected clock by 1, 2, 4 or 8.
// - oscillator enable bit turns the dedicated oscillator on or off.
// - for source 10 (pin or crystal) the sync bit 1 bypasses, 0 synchronises.
// - for internal sources the sync bit is ignored.
// - run bit enables counting; clearing it stops and clears the gate toggle.
// - count rolls from ffff to 0000 and sets the overflow flag.
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_timer #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic external_clock_pin,
  input wire logic crystal_input_pin,
  input wire logic capacitive_sensing_oscillator,
  input wire logic capture_event,
  output logic crystal_output_pin,
  output logic oscillator_enable_out,
  output logic compare_event,
  output logic overflow_interrupt_flag
);
  import tmo_pkg::*;

  logic [7:0] control;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] compare_value_low_byte;
  logic [7:0] compare_value_high_byte;
  logic [7:0] capture_low;
  logic [7:0] capture_high;
  logic [1:0] unit_mode;
  tmo_bus_e bus_state;
  logic [1:0] instr_div;
  logic [2:0] prescale_cnt;
  logic [2:0] pin_sync;
  logic [2:0] xtal_sync;
  logic [2:0] sense_sync;
  logic gate_toggle;
  logic compare_hit_q;
  logic match_seen;
  logic [1:0] ext_align;

  logic [1:0] clock_source_select;
  logic [1:0] input_prescale_select;
  logic dedicated_oscillator_enable;
  logic external_clock_sync_bit;
  logic timer_run_bit;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] compare_value;
  logic ext_raw_level;
  logic ext_sync_rise;
  logic ext_async_rise;
  logic sense_rise;
  logic source_tick;
  logic count_tick;
  logic [2:0] prescale_top;
  logic bus_write;
  logic write_count_low;
  logic write_count_high;
  logic compare_match;
  logic special_trigger;
  logic count_wrap;
  logic compare_fire;
  logic bus_read_take;

  assign clock_source_select = control[`TMO_POS_SOURCE +: 2];
  assign input_prescale_select = control[`TMO_POS_PRESCALE +: 2];
  assign dedicated_oscillator_enable = control[`TMO_BIT_OSC_EN];
  assign external_clock_sync_bit = control[`TMO_BIT_SYNC];
  assign timer_run_bit = control[`TMO_BIT_RUN];
  assign count = {count_high_byte, count_low_byte};
  assign compare_value = {compare_value_high_byte, compare_value_low_byte};

  // single wait state: a write is taken on the ack edge only
  assign bus_write = write && (bus_state == tmo_bus_ack);
  // read data is fetched on the first edge so it stands during the ack cycle
  assign bus_read_take = read && (bus_state == tmo_bus_idle);
  assign write_count_low = bus_write && (address == `TMO_OFS_COUNT_LOW);
  assign write_count_high = bus_write && (address == `TMO_OFS_COUNT_HIGH);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state <= tmo_bus_idle;
      waitrequest <= 1'b1;
    end else if ((read || write) && bus_state == tmo_bus_idle) begin
      bus_state <= tmo_bus_ack;
      waitrequest <= 1'b0;
    end else begin
      bus_state <= tmo_bus_idle;
      waitrequest <= 1'b1;
    end
  end

  function automatic logic [7:0] reg_read(input logic [3:0] a, input logic [7:0] c,
                                          input logic [CNT_W-1:0] cn,
                                          input logic [CNT_W-1:0] cv,
                                          input logic [15:0] cp,
                                          input logic [1:0] m, input logic f);
    case (a)
      `TMO_OFS_CONTROL: reg_read = c;
      `TMO_OFS_COUNT_LOW: reg_read = cn[7:0];
      `TMO_OFS_COUNT_HIGH: reg_read = cn[15:8];
      `TMO_OFS_COMPARE_LOW: reg_read = cv[7:0];
      `TMO_OFS_COMPARE_HIGH: reg_read = cv[15:8];
      `TMO_OFS_UNIT_CONTROL: reg_read = {6'h00, m};
      `TMO_OFS_STATUS: reg_read = {7'h00, f};
      `TMO_OFS_CAPTURE_LOW: reg_read = cp[7:0];
      `TMO_OFS_CAPTURE_HIGH: reg_read = cp[15:8];
      default: reg_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (bus_read_take) begin
      readdata <= {24'h000000, reg_read(address, control, count, compare_value,
                                        {capture_high, capture_low}, unit_mode,
                                        overflow_interrupt_flag)};
    end
  end

  // bit 1 is not implemented and is masked off on every write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= `TMO_CONTROL_RESET;
    end else if (bus_write && address == `TMO_OFS_CONTROL) begin
      control <= writedata[7:0] & `TMO_CONTROL_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_value_low_byte <= 8'h00;
      compare_value_high_byte <= 8'h00;
      unit_mode <= 2'h0;
    end else if (bus_write) begin
      if (address == `TMO_OFS_COMPARE_LOW) begin
        compare_value_low_byte <= writedata[7:0];
      end
      if (address == `TMO_OFS_COMPARE_HIGH) begin
        compare_value_high_byte <= writedata[7:0];
      end
      if (address == `TMO_OFS_UNIT_CONTROL) begin
        unit_mode <= writedata[1:0];
      end
    end
  end

  // oscillator enable and crystal drive
  // drive opposes the sampled input, as an inverting amplifier would
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oscillator_enable_out <= 1'b0;
      crystal_output_pin <= 1'b0;
    end else begin
      oscillator_enable_out <= dedicated_oscillator_enable;
      crystal_output_pin <= dedicated_oscillator_enable && !xtal_sync[1];
    end
  end

  // three stages: first two synchronise, third gives the edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_sync <= 3'h0;
      xtal_sync <= 3'h0;
      sense_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_clock_pin};
      xtal_sync <= {xtal_sync[1:0], crystal_input_pin};
      sense_sync <= {sense_sync[1:0], capacitive_sensing_oscillator};
    end
  end

  assign ext_raw_level = dedicated_oscillator_enable ? xtal_sync[1] : pin_sync[1];
  assign ext_sync_rise = ext_align[0] && !ext_align[1];
  // unsynchronised path: still sampled, but without the extra alignment stage
  assign ext_async_rise = ext_raw_level && !(dedicated_oscillator_enable ? xtal_sync[2]
                                                                         : pin_sync[2]);
  assign sense_rise = sense_sync[1] && !sense_sync[2];

  // synchronised path pays one more cycle of latency for a clean edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_align <= 2'h0;
    end else begin
      ext_align <= {ext_align[0], ext_raw_level};
    end
  end

  // free-running quarter-rate tick for the instruction clock source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // only code 10 looks at the sync bit
  always_comb begin
    case (tmo_src_e'(clock_source_select))
      tmo_src_instr: source_tick = (instr_div == `TMO_INSTR_DIV);
      tmo_src_sys: source_tick = 1'b1;
      tmo_src_pin: source_tick = external_clock_sync_bit ? ext_async_rise
                                                         : ext_sync_rise;
      tmo_src_sense: source_tick = sense_rise;
      default: source_tick = 1'b0;
    endcase
  end

  // terminal prescaler count for 1:1, 1:2, 1:4 and 1:8
  always_comb begin
    case (input_prescale_select)
      2'h0: prescale_top = 3'h0;
      2'h1: prescale_top = 3'h1;
      2'h2: prescale_top = 3'h3;
      default: prescale_top = 3'h7;
    endcase
  end

  assign count_tick = timer_run_bit && source_tick && (prescale_cnt == prescale_top);
  // rollover of the full count; a clear or a byte write never counts as one
  assign count_wrap = count_tick && (count == 16'hffff);

  // restarts while stopped so every run begins on a full prescale period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale_cnt <= 3'h0;
    end else if (!timer_run_bit) begin
      prescale_cnt <= 3'h0;
    end else if (source_tick) begin
      prescale_cnt <= (prescale_cnt >= prescale_top) ? 3'h0 : prescale_cnt + 3'h1;
    end
  end

  // kept for the gate logic; nothing in this block reads it yet
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_toggle <= 1'b0;
    end else if (!timer_run_bit) begin
      gate_toggle <= 1'b0;
    end else if (count_tick) begin
      gate_toggle <= !gate_toggle;
    end
  end

  assign compare_match = (compare_value == count);
  assign special_trigger = compare_hit_q && (unit_mode == tmo_mode_special);

  function automatic logic compare_armed(input logic [1:0] m);
    compare_armed = (m == tmo_mode_compare) || (m == tmo_mode_special);
  endfunction

  // a match held over several cycles fires only once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      match_seen <= 1'b0;
    end else begin
      match_seen <= compare_match;
    end
  end

  assign compare_fire = compare_match && !match_seen && compare_armed(unit_mode);

  // event in the cycle after the first cycle of a match, not for as long as the count stays there
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_hit_q <= 1'b0;
      compare_event <= 1'b0;
    end else begin
      compare_hit_q <= compare_fire;
      compare_event <= compare_fire;
    end
  end

  // a count byte write beats the trigger clear and the tick alike
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
    end else begin
      if (write_count_low || write_count_high) begin
        if (write_count_low) begin
          count_low_byte <= writedata[7:0];
        end
        if (write_count_high) begin
          count_high_byte <= writedata[7:0];
        end
      end else if (special_trigger) begin
        count_low_byte <= 8'h00;
        count_high_byte <= 8'h00;
      end else if (count_tick) begin
        {count_high_byte, count_low_byte} <= count + 16'h0001;
      end
    end
  end

  // flag set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overflow_interrupt_flag <= 1'b0;
    end else if (count_wrap && !special_trigger && !write_count_low && !write_count_high) begin
      overflow_interrupt_flag <= 1'b1;
    end else if (bus_write && address == `TMO_OFS_STATUS && !writedata[0]) begin
      overflow_interrupt_flag <= 1'b0;
    end
  end

  // capture takes the count as it stood before this edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capture_low <= 8'h00;
      capture_high <= 8'h00;
    end else if (capture_event && unit_mode == tmo_mode_capture) begin
      capture_low <= count_low_byte;
      capture_high <= count_high_byte;
    end
  end
endmodule

// >>> src/tmo_map.svh
// register offsets, field positions and reset values of the timer block
`ifndef TMO_MAP_SVH
`define TMO_MAP_SVH
`define TMO_OFS_CONTROL 4'h0
`define TMO_OFS_COUNT_LOW 4'h1
`define TMO_OFS_COUNT_HIGH 4'h2
`define TMO_OFS_COMPARE_LOW 4'h3
`define TMO_OFS_COMPARE_HIGH 4'h4
`define TMO_OFS_UNIT_CONTROL 4'h5
`define TMO_OFS_STATUS 4'h6
`define TMO_OFS_CAPTURE_LOW 4'h7
`define TMO_OFS_CAPTURE_HIGH 4'h8
`define TMO_BIT_RUN 0
`define TMO_BIT_SYNC 2
`define TMO_BIT_OSC_EN 3
`define TMO_POS_PRESCALE 4
`define TMO_POS_SOURCE 6
`define TMO_CONTROL_WMASK 8'hfd
`define TMO_CONTROL_RESET 8'h00
`define TMO_INSTR_DIV 2'h3
`endif

// >>> src/tmo_pkg.sv
// types of the timer block
package tmo_pkg;
  typedef enum logic [1:0] {
    tmo_src_instr = 2'h0,
    tmo_src_sys = 2'h1,
    tmo_src_pin = 2'h2,
    tmo_src_sense = 2'h3
  } tmo_src_e;
  typedef enum logic [1:0] {
    tmo_mode_off = 2'h0,
    tmo_mode_capture = 2'h1,
    tmo_mode_compare = 2'h2,
    tmo_mode_special = 2'h3
  } tmo_mode_e;
  typedef enum {tmo_bus_idle, tmo_bus_ack} tmo_bus_e;
endpackage

// >>> sim/tmo_timer_checker.sv
// concurrent checks on the timer block ports
`timescale 1ns/10ps
module tmo_timer_checker #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic crystal_output_pin,
  input wire logic oscillator_enable_out,
  input wire logic compare_event,
  input wire logic overflow_interrupt_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_req_acked:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no ack");
  chk_ack_single:
    assert property (!waitrequest |=> waitrequest) else $error("ack too long");
  chk_idle_no_ack:
    assert property (waitrequest && !read && !write |=> waitrequest) else $error("stray ack");
  chk_read_upper:
    assert property (!waitrequest && read |-> readdata[31:8] == 24'h0) else $error("upper bits");
  chk_ctl_bit_one:
    assert property (!waitrequest && read && address == 4'h0 |-> !readdata[1])
    else $error("bit1 set");
  chk_unmapped_zero:
    assert property (!waitrequest && read && address > 4'h8 |-> readdata == 32'h0)
    else $error("unmapped read");
  chk_cmp_pulse:
    assert property (compare_event |=> !compare_event) else $error("event too long");
  chk_flag_sticky:
    assert property (overflow_interrupt_flag && !(write && address == 4'h6)
      |=> overflow_interrupt_flag) else $error("flag lost");
  chk_osc_off_idle:
    assert property (!oscillator_enable_out [*2] |-> !crystal_output_pin)
    else $error("osc drive while off");
endmodule
bind tmo_timer tmo_timer_checker #(.CNT_W(CNT_W)) tmo_timer_checker_i (.sys_clk(sys_clk),
  .rst(rst), .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .crystal_output_pin(crystal_output_pin),
  .oscillator_enable_out(oscillator_enable_out), .compare_event(compare_event),
  .overflow_interrupt_flag(overflow_interrupt_flag));

// >>> sim/tmo_clock_source.sv
// far-side count clocks: pin clock, crystal and sensing oscillator
`timescale 1ns/10ps
module tmo_clock_source #(
  parameter int PIN_HALF = 40,
  parameter int XTAL_HALF = 80,
  parameter int SENSE_HALF = 24
) (
  input wire logic oscillator_enable_out,
  output logic external_clock_pin,
  output logic crystal_input_pin,
  output logic capacitive_sensing_oscillator
);
  // odd start offsets keep the phases unrelated to the system clock
  initial begin
    external_clock_pin = 1'b0;
    #3;
    forever #PIN_HALF external_clock_pin = ~external_clock_pin;
  end
  // a crystal only swings while its oscillator is powered
  initial begin
    crystal_input_pin = 1'b0;
    forever begin
      #XTAL_HALF;
      crystal_input_pin = oscillator_enable_out & ~crystal_input_pin;
    end
  end
  initial begin
    capacitive_sensing_oscillator = 1'b0;
    #5;
    forever #SENSE_HALF capacitive_sensing_oscillator = ~capacitive_sensing_oscillator;
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the timer block
`timescale 1ns/10ps
module testbench;
  import tmo_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, capture_event = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, ext_pin, xtal_in, sense_osc, xtal_out, osc_en, cmp_ev, ovf;
  logic [7:0] q, lo, hi;
  logic [7:0] ctls [10] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h00, 8'h04, 8'h80, 8'h84, 8'h88, 8'hc0};
  int divs [10] = '{1, 2, 4, 8, 4, 4, 10, 10, 20, 6};
  int n_fail = 0, n_tests = 0, t;
  always #4 sys_clk = ~sys_clk;
  tmo_timer #(.CNT_W(16)) tmo_timer_i (.sys_clk(sys_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .external_clock_pin(ext_pin), .crystal_input_pin(xtal_in),
    .capacitive_sensing_oscillator(sense_osc), .capture_event(capture_event),
    .crystal_output_pin(xtal_out), .oscillator_enable_out(osc_en), .compare_event(cmp_ev),
    .overflow_interrupt_flag(ovf));
  tmo_clock_source tmo_clock_source_i (.oscillator_enable_out(osc_en),
    .external_clock_pin(ext_pin), .crystal_input_pin(xtal_in),
    .capacitive_sensing_oscillator(sense_osc));
  task automatic conclude;
    $display("tests %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one slave access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [3:0] a); bus(1'b0, a, 8'h0); endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input logic [15:0] got, input int exp, input int tol);
    n_tests++;
    if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("MISMATCH %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // counts from zero for about 203 cycles, then stops and reads back
  task automatic run_for(input logic [7:0] ctl);
    wr(4'h1, 8'h0);
    wr(4'h2, 8'h0);
    wr(4'h0, ctl | 8'h01);
    repeat (200) @(posedge sys_clk);
    wr(4'h0, ctl);
    rd(4'h1);
    lo = q;
    rd(4'h2);
    hi = q;
    repeat (8) @(posedge sys_clk);
    rd(4'h1);
  endtask
  task automatic waitev;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (cmp_ev !== 1'b1 && t < 300);
    if (t >= 300) begin
      n_fail++;
      $display("MISMATCH %0t: no compare event", $time);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0); chk8(q, 8'h00);
    wr(4'h0, 8'hff); rd(4'h0); chk8(q, 8'hfd);
    chk8({7'h0, osc_en}, 8'h01);
    rd(4'hf); chk8(q, 8'h00);
    for (int i = 0; i < 10; i++) begin
      run_for(ctls[i]);
      chk8(q, lo);
      chkn({hi, lo}, 203 / divs[i], 3);
    end
    wr(4'h1, 8'h34); wr(4'h2, 8'h12); wr(4'h5, 8'h01);
    @(posedge sys_clk) capture_event <= 1'b1;
    @(posedge sys_clk) capture_event <= 1'b0;
    rd(4'h7); chk8(q, 8'h34);
    rd(4'h8); chk8(q, 8'h12);
    wr(4'h1, 8'h0); wr(4'h2, 8'h0); wr(4'h3, 8'h09); wr(4'h4, 8'h0);
    wr(4'h5, 8'h03); wr(4'h6, 8'h0);
    wr(4'h0, 8'h41);
    waitev;
    waitev; chkn(t, 11, 0);
    // the next trigger clear falls on the edge at which this write lands
    repeat (8) @(posedge sys_clk);
    wr(4'h1, 8'h55);
    wr(4'h0, 8'h00); rd(4'h1); chk8(q, 8'h58);
    rd(4'h6); chk8(q, 8'h00);
    wr(4'h1, 8'h0); wr(4'h5, 8'h02); wr(4'h0, 8'h41);
    waitev;
    repeat (10) @(posedge sys_clk);
    wr(4'h0, 8'h00); rd(4'h1); chkn({8'h0, q}, 23, 3);
    wr(4'h5, 8'h00); wr(4'h1, 8'hf0); wr(4'h2, 8'hff); wr(4'h0, 8'h41);
    repeat (40) @(posedge sys_clk);
    wr(4'h0, 8'h00); rd(4'h6); chk8(q, 8'h01);
    rd(4'h2); chk8(q, 8'h00);
    wr(4'h6, 8'h00); rd(4'h6); chk8(q, 8'h00);
    conclude;
  end
  initial begin
    #100000;
    n_fail++;
    $display("MISMATCH %0t: timeout", $time);
    conclude;
  end
endmodule
